/* File: shared/pmwc_pkg.sv */
/*
 * Constants, register map and bus carriers for the power mode and wakeup
 * controller. Assumes an AXI4-Lite master with 32-bit data and 8-bit
 * byte addresses.
 */
package pmwc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] OSC_MODE_OFF = 8'hC8;
    localparam logic [ADDR_W-1:0] TIMER_MODE_OFF = 8'hD8;
    localparam logic [ADDR_W-1:0] TIMER_RUN_OFF = 8'hDC;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 8'hE0;

    // Oscillator mode register fields.
    localparam int OSC_STOP_BIT = 1;
    localparam int OSC_CLK_BIT = 2;
    localparam int OSC_MODE_LSB = 3;

    // Timer mode register fields.
    localparam int TM_T0GN_BIT = 1;
    localparam int TM_T0X8_BIT = 2;
    localparam int TM_T1X8_BIT = 3;

    // Timer run register fields.
    localparam int RUN_T0_BIT = 0;
    localparam int RUN_T1_BIT = 1;

    // Status register fields.
    localparam int STAT_CPU_BIT = 0;
    localparam int STAT_HOSC_BIT = 1;
    localparam int STAT_LRC_BIT = 2;
    localparam int STAT_SETTLE_BIT = 3;
    localparam int STAT_T0_BIT = 4;
    localparam int STAT_T1_BIT = 5;

    // Values after reset.
    localparam logic [7:0] OSC_MODE_RST = 8'h00;
    localparam logic [7:0] TIMER_MODE_RST = 8'h00;
    localparam logic [7:0] TIMER_RUN_RST = 8'h00;

    // CPU operating mode codes.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_GREEN = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;

    // Counts in cycles of the clock being counted.
    localparam int SETTLE_CLOCKS = 2048;
    localparam int SLOW_DIV = 4;
    localparam int DIV_W = $clog2(SLOW_DIV);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_RUN, ST_GREEN, ST_SLEEP, ST_SETTLE} pmwc_state_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } pmwc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } pmwc_axi_rsp_t;

endpackage

/* File: src/pmwc_sync.sv */
/*
 * Two-flop synchroniser for a group of pins, with change and rising-edge
 * pulses taken from the second and third stages. Assumes the pins are
 * asynchronous to aclk and slower than half its rate.
 */
`timescale 1ns/10ps
module pmwc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic [W-1:0] pin,
    // Synchronised view
    output logic [W-1:0] level,
    output logic change,
    output logic rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } pmwc_sync_regs_t;

    pmwc_sync_regs_t r;
    pmwc_sync_regs_t next_r;

    if (W < 1) begin : g_chk
        $error("pmwc_sync needs at least one pin.");
    end

    // The first stage feeds only the second; edges are judged one stage later.
    always_comb begin
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.s2;
    assign change = |(r.s2 ^ r.s3);
    assign rise = |(r.s2 & ~r.s3);
endmodule

/* File: src/pmwc_ctrl.sv */
/*
 * Power mode and wakeup controller: run, green, sleep and settle states,
 * oscillator, CPU and timer gating, and an AXI4-Lite register slave.
 * Assumes oscillator clocks arrive as slow pins and timer overflow and
 * watchdog enable come from logic on aclk.
 */
// Contract
// - Slow instruction rate is low clock over four.
// - Low RC clocks watchdog and slow system clock.
// - Low RC stops in sleep or green-slow-nowatchdog.
// - No separate low RC disable control.
// - CPU halts in sleep and green until wakeup.
// - Timers run when enabled, never in sleep.
// - Sleep wakes only on port or reset.
// - Green without timer wake: port or reset.
// - Timer-0 overflow wakes green when enabled.
// - Green wakeup returns to previous mode.
// - Sleep wakeup enters normal, port change only.
// - Sleep wakeup waits 2048 high clocks.
// - Green wakeup has no settling delay.
// - Timer mode bit 1 enables green wake.
// - Mode field: normal, sleep, green, reserved.
// - Clock select one is slow, zero normal.
// - High stop bit halts high oscillator only, in green or in slow-clock run.
`timescale 1ns/10ps
module pmwc_ctrl #(
    parameter int PORT_W = 8,
    parameter int SETTLE_CLOCKS = pmwc_pkg::SETTLE_CLOCKS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire pmwc_pkg::pmwc_axi_req_t axi_req,
    output pmwc_pkg::pmwc_axi_rsp_t axi_rsp,
    // Pins and event sources
    input wire logic [PORT_W-1:0] wake_port,
    input wire logic hosc_clk_pin,
    input wire logic lrc_clk_pin,
    input wire logic timer0_overflow,
    input wire logic watchdog_enable,
    // Oscillator and CPU control
    output logic high_osc_run,
    output logic low_rc_run,
    output logic sys_clk_low,
    output logic cpu_run,
    output logic cpu_tick,
    output logic settling,
    // Timer control
    output logic timer0_active,
    output logic timer1_active,
    output logic timer0_fast_clock_select,
    output logic timer1_fast_clock_select
);
    import pmwc_pkg::*;

    localparam int CNT_W = $clog2(SETTLE_CLOCKS);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CLOCKS - 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);

    if (SETTLE_CLOCKS < 2 || SETTLE_CLOCKS > 65536 || PORT_W < 1) begin : g_chk
        $error("pmwc_ctrl parameters out of range.");
    end

    typedef struct packed {
        pmwc_state_t st;
        logic [1:0] cpu_mode;
        logic clk_low;
        logic hosc_stop;
        logic t0_gn;
        logic t0_x8;
        logic t1_x8;
        logic t0_run;
        logic t1_run;
        logic [CNT_W-1:0] settle_cnt;
        logic [DIV_W-1:0] quarter;
        logic hosc_on;
        logic lrc_on;
        logic cpu_run;
        logic cpu_tick;
        logic t0_act;
        logic t1_act;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [7:0] wdata;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } pmwc_regs_t;

    localparam pmwc_regs_t REGS_RST = '{
        st: ST_RUN,
        cpu_mode: OSC_MODE_RST[OSC_MODE_LSB +: 2],
        clk_low: OSC_MODE_RST[OSC_CLK_BIT],
        hosc_stop: OSC_MODE_RST[OSC_STOP_BIT],
        t0_gn: TIMER_MODE_RST[TM_T0GN_BIT],
        t0_x8: TIMER_MODE_RST[TM_T0X8_BIT],
        t1_x8: TIMER_MODE_RST[TM_T1X8_BIT],
        t0_run: TIMER_RUN_RST[RUN_T0_BIT],
        t1_run: TIMER_RUN_RST[RUN_T1_BIT],
        hosc_on: 1'b1,
        lrc_on: 1'b1,
        cpu_run: 1'b1,
        bresp: RESP_OKAY,
        rresp: RESP_OKAY,
        default: '0
    };

    function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
        word_of = {a[ADDR_W-1:2], 2'h0};
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = word_of(a);
        reg_hit = (w == OSC_MODE_OFF) || (w == TIMER_MODE_OFF) ||
            (w == TIMER_RUN_OFF) || (w == STATUS_OFF);
    endfunction

    pmwc_regs_t r;
    pmwc_regs_t n;
    logic port_chg;
    logic hosc_rise;
    logic lrc_rise;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wd;
    logic wl;
    logic t0_wake;

    pmwc_sync #(.W(PORT_W)) u_port_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(wake_port),
        .level(),
        .change(port_chg),
        .rise()
    );

    // One synchroniser per oscillator pin, so no two first stages can disagree.
    pmwc_sync #(.W(1)) u_hosc_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(hosc_clk_pin),
        .level(),
        .change(),
        .rise(hosc_rise)
    );

    pmwc_sync #(.W(1)) u_lrc_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(lrc_clk_pin),
        .level(),
        .change(),
        .rise(lrc_rise)
    );

    always_comb begin
        n = r;
        aw_hs = axi_req.awvalid && !r.aw_got && !r.bvalid;
        w_hs = axi_req.wvalid && !r.w_got && !r.bvalid;
        ar_hs = axi_req.arvalid && !r.rvalid;
        wr_fire = (r.aw_got || aw_hs) && (r.w_got || w_hs);
        waddr = r.aw_got ? r.aw_addr : axi_req.awaddr;
        wd = r.w_got ? r.wdata : axi_req.wdata[7:0];
        wl = r.w_got ? r.wlane : axi_req.wstrb[0];
        t0_wake = timer0_overflow && r.t0_gn && r.t0_act;
        if (aw_hs) begin
            n.aw_got = 1'b1;
            n.aw_addr = axi_req.awaddr;
        end
        if (w_hs) begin
            n.w_got = 1'b1;
            n.wdata = axi_req.wdata[7:0];
            n.wlane = axi_req.wstrb[0];
        end
        if (r.bvalid && axi_req.bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_fire) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = reg_hit(waddr) ? RESP_OKAY : RESP_SLVERR;
            if (wl) begin
                unique case (word_of(waddr))
                    OSC_MODE_OFF: begin
                        n.hosc_stop = wd[OSC_STOP_BIT];
                        n.clk_low = wd[OSC_CLK_BIT];
                        // The reserved code is dropped so the field never holds it.
                        if (r.st == ST_RUN && wd[OSC_MODE_LSB +: 2] != MODE_RSVD) begin
                            n.cpu_mode = wd[OSC_MODE_LSB +: 2];
                        end
                    end
                    TIMER_MODE_OFF: begin
                        n.t0_gn = wd[TM_T0GN_BIT];
                        n.t0_x8 = wd[TM_T0X8_BIT];
                        n.t1_x8 = wd[TM_T1X8_BIT];
                    end
                    TIMER_RUN_OFF: begin
                        n.t0_run = wd[RUN_T0_BIT];
                        n.t1_run = wd[RUN_T1_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (r.rvalid && axi_req.rready) begin
            n.rvalid = 1'b0;
        end
        if (ar_hs) begin
            n.rvalid = 1'b1;
            n.rresp = reg_hit(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
            n.rdata = '0;
            unique case (word_of(axi_req.araddr))
                OSC_MODE_OFF: begin
                    n.rdata[OSC_MODE_LSB +: 2] = r.cpu_mode;
                    n.rdata[OSC_CLK_BIT] = r.clk_low;
                    n.rdata[OSC_STOP_BIT] = r.hosc_stop;
                end
                TIMER_MODE_OFF: begin
                    n.rdata[TM_T0GN_BIT] = r.t0_gn;
                    n.rdata[TM_T0X8_BIT] = r.t0_x8;
                    n.rdata[TM_T1X8_BIT] = r.t1_x8;
                end
                TIMER_RUN_OFF: begin
                    n.rdata[RUN_T0_BIT] = r.t0_run;
                    n.rdata[RUN_T1_BIT] = r.t1_run;
                end
                STATUS_OFF: begin
                    n.rdata[STAT_CPU_BIT] = r.cpu_run;
                    n.rdata[STAT_HOSC_BIT] = r.hosc_on;
                    n.rdata[STAT_LRC_BIT] = r.lrc_on;
                    n.rdata[STAT_SETTLE_BIT] = (r.st == ST_SETTLE);
                    n.rdata[STAT_T0_BIT] = r.t0_act;
                    n.rdata[STAT_T1_BIT] = r.t1_act;
                end
                default: begin
                end
            endcase
        end
        unique case (r.st)
            ST_RUN: begin
                if (n.cpu_mode == MODE_SLEEP) begin
                    n.st = ST_SLEEP;
                end else if (n.cpu_mode == MODE_GREEN) begin
                    n.st = ST_GREEN;
                end
            end
            ST_SLEEP: begin
                // Only the port wakes a sleeping part; timer overflow is ignored.
                if (port_chg) begin
                    n.st = ST_SETTLE;
                    n.cpu_mode = MODE_NORMAL;
                    n.clk_low = 1'b0;
                    n.hosc_stop = 1'b0;
                    n.settle_cnt = '0;
                end
            end
            ST_SETTLE: begin
                if (hosc_rise) begin
                    if (r.settle_cnt == CNT_LAST) begin
                        n.st = ST_RUN;
                    end else begin
                        n.settle_cnt = r.settle_cnt + 1'b1;
                    end
                end
            end
            ST_GREEN: begin
                // No settling state on this path, so the return is immediate and clk_low is kept.
                if (port_chg || t0_wake) begin
                    n.st = ST_RUN;
                    n.cpu_mode = MODE_NORMAL;
                end
            end
        endcase
        n.cpu_tick = 1'b0;
        if (r.st == ST_RUN && n.st == ST_RUN) begin
            if (r.clk_low) begin
                if (lrc_rise) begin
                    n.quarter = (r.quarter == DIV_LAST) ? '0 : r.quarter + 1'b1;
                    n.cpu_tick = (r.quarter == DIV_LAST);
                end
            end else begin
                n.cpu_tick = hosc_rise;
            end
        end
        n.hosc_on = (n.st == ST_SETTLE) || (n.st == ST_RUN && !(n.hosc_stop && n.clk_low)) ||
            (n.st == ST_GREEN && !n.hosc_stop);
        // No bit of its own stops the low RC; it follows mode and watchdog alone.
        n.lrc_on = (n.st != ST_SLEEP) &&
            !(n.st == ST_GREEN && n.clk_low && !watchdog_enable);
        n.cpu_run = (n.st == ST_RUN);
        n.t0_act = (n.st == ST_RUN || n.st == ST_GREEN) && n.t0_run;
        n.t1_act = (n.st == ST_RUN || n.st == ST_GREEN) && n.t1_run;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    always_comb begin
        axi_rsp.awready = !r.aw_got && !r.bvalid;
        axi_rsp.wready = !r.w_got && !r.bvalid;
        axi_rsp.bvalid = r.bvalid;
        axi_rsp.bresp = r.bresp;
        axi_rsp.arready = !r.rvalid;
        axi_rsp.rvalid = r.rvalid;
        axi_rsp.rdata = r.rdata;
        axi_rsp.rresp = r.rresp;
    end

    assign high_osc_run = r.hosc_on;
    assign low_rc_run = r.lrc_on;
    assign sys_clk_low = r.clk_low;
    assign cpu_run = r.cpu_run;
    assign cpu_tick = r.cpu_tick;
    assign settling = (r.st == ST_SETTLE);
    assign timer0_active = r.t0_act;
    assign timer1_active = r.t1_act;
    assign timer0_fast_clock_select = r.t0_x8;
    assign timer1_fast_clock_select = r.t1_x8;

    // High clock edges seen since settling began; read only by the checks.
    logic [16:0] seen_edges;
    always_ff @(posedge aclk) begin
        if (!aresetn || r.st != ST_SETTLE) begin
            seen_edges <= '0;
        end else if (hosc_rise) begin
            seen_edges <= seen_edges + 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_sleep_gates: assert property (r.st == ST_SLEEP |->
        !high_osc_run && !low_rc_run && !cpu_run && !timer0_active && !timer1_active)
        else $error("Sleep left a clock, timer or the CPU running.");
    chk_sleep_wake: assert property (r.st == ST_SLEEP && port_chg |=>
        r.st == ST_SETTLE && r.cpu_mode == MODE_NORMAL && !sys_clk_low && high_osc_run)
        else $error("Port change did not start settling toward normal.");
    chk_sleep_hold: assert property (r.st == ST_SLEEP && !port_chg |=> r.st == ST_SLEEP)
        else $error("Sleep left without a port change.");
    chk_settle_len: assert property ($fell(r.st == ST_SETTLE) |->
        r.st == ST_RUN && $past(hosc_rise) && int'($past(seen_edges)) == SETTLE_CLOCKS - 1)
        else $error("Settling did not last the full high clock count.");
    chk_green_return: assert property (r.st == ST_GREEN && port_chg |=>
        r.st == ST_RUN && cpu_run && $stable(r.clk_low) && r.cpu_mode == MODE_NORMAL)
        else $error("Green wakeup did not return at once to the prior mode.");
    chk_green_timer: assert property (r.st == ST_GREEN && timer0_overflow &&
        r.t0_gn && timer0_active |=> r.st == ST_RUN)
        else $error("Enabled timer-0 overflow did not wake green mode.");
    chk_green_no_timer: assert property (r.st == ST_GREEN && !port_chg && !r.t0_gn |=>
        r.st == ST_GREEN)
        else $error("Green mode woke without port change or timer wake.");
    chk_slow_div: assert property (cpu_tick && $past(r.st == ST_RUN && r.clk_low) |->
        $past(lrc_rise) && $past(r.quarter) == DIV_LAST)
        else $error("Slow instruction tick not on every fourth low clock.");
    chk_lrc_green: assert property (r.st == ST_GREEN && $past(r.st == ST_GREEN) |->
        low_rc_run == !(r.clk_low && !$past(watchdog_enable)))
        else $error("Low RC state in green does not follow mode and watchdog.");
    chk_timer_gate: assert property (r.st == ST_RUN |-> timer0_active == r.t0_run &&
        timer1_active == r.t1_run)
        else $error("Timer activity does not follow its enable.");

    cov_sleep_cycle: cover property (r.st == ST_SLEEP ##1 r.st == ST_SETTLE);
    cov_settle_done: cover property ($fell(r.st == ST_SETTLE));
    cov_green_timer: cover property (r.st == ST_GREEN && timer0_overflow && r.t0_gn);
    cov_slow_tick: cover property (cpu_tick && r.clk_low);
endmodule

/* File: bench/pmwc_ctrl_tb.sv */
/*
 * Self-checking bench for pmwc_ctrl: AXI4-Lite master tasks, oscillator and
 * port pin stimulus, and a small register model. Assumes SETTLE_CLOCKS is cut to 8.
 */
`timescale 1ns/10ps
module pmwc_ctrl_tb;
    import pmwc_pkg::*;
    localparam int ST = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    pmwc_axi_req_t req = '0;
    pmwc_axi_rsp_t rsp;
    logic [7:0] wake_port = 8'h00;
    logic hosc = 1'b0;
    logic lrc = 1'b0;
    logic ovf = 1'b0;
    logic wdog = 1'b0;
    logic hosc_run, lrc_run, clk_low, cpu_run, cpu_tick, settling;
    logic t0_act, t1_act, t0_fast, t1_fast;
    logic [3:0] cyc = 4'h0;
    logic saw_settle = 1'b0;
    int h_rises = 0;
    int l_rises = 0;
    int n_errors = 0;
    int check_count = 0;
    int osc_m = 0;
    int tmr_m = 0;
    int run_m = 0;
    int n;
    int k;

    always #10 aclk = ~aclk;

    // Oscillator pins stand still while their enable is low, as the real ones would.
    always @(posedge aclk) begin
        cyc <= cyc + 4'h1;
        if (settling === 1'b1) saw_settle <= 1'b1;
        if (hosc_run && cyc[0]) begin
            hosc <= ~hosc;
            h_rises <= h_rises + int'(!hosc);
        end
        if (lrc_run && cyc[2:0] == 3'h0) begin
            lrc <= ~lrc;
            l_rises <= l_rises + int'(!lrc);
        end
    end

    pmwc_ctrl #(.PORT_W(8), .SETTLE_CLOCKS(ST)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .wake_port(wake_port), .hosc_clk_pin(hosc), .lrc_clk_pin(lrc),
        .timer0_overflow(ovf), .watchdog_enable(wdog), .high_osc_run(hosc_run),
        .low_rc_run(lrc_run), .sys_clk_low(clk_low), .cpu_run(cpu_run),
        .cpu_tick(cpu_tick), .settling(settling), .timer0_active(t0_act),
        .timer1_active(t1_act), .timer0_fast_clock_select(t0_fast),
        .timer1_fast_clock_select(t1_fast)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic timeout();
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        end_of_test();
    endtask

    function automatic logic [31:0] resp_of(input logic [7:0] a);
        logic hit;
        hit = (a == OSC_MODE_OFF || a == TIMER_MODE_OFF || a == TIMER_RUN_OFF || a == STATUS_OFF);
        return {30'h0, hit ? RESP_OKAY : RESP_SLVERR};
    endfunction

    // The model follows each write; mode codes land only while running, never code 11.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        req.bready <= 1'b0;
        check({30'h0, rsp.bresp}, resp_of(a));
        if (a == TIMER_MODE_OFF) tmr_m = d & 32'h0E;
        if (a == TIMER_RUN_OFF) run_m = d & 32'h03;
        if (a == OSC_MODE_OFF) begin
            osc_m = (osc_m & 32'h18) | (d & 32'h06);
            if (osc_m[4:3] == 2'h0 && d[4:3] != 2'h3) osc_m[4:3] = d[4:3];
        end
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        int i;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        req.rready <= 1'b0;
        check(rsp.rdata, e);
        check({30'h0, rsp.rresp}, resp_of(a));
        @(posedge aclk);
    endtask

    // Waits a bounded number of cycles for cpu_run (sel 0) or settling (sel 1).
    task automatic wait_for(input int sel, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge aclk);
            if ((sel == 0 ? cpu_run : settling) === v) break;
        end
        if (i == lim) timeout();
    endtask

    task automatic count_ticks(input int cycles, output int ticks, output int rises);
        ticks = 0;
        rises = l_rises;
        repeat (cycles) begin
            @(posedge aclk);
            ticks += int'(cpu_tick === 1'b1);
        end
        rises = l_rises - rises;
    endtask

    task automatic pulse_ovf();
        ovf <= 1'b1;
        @(posedge aclk);
        ovf <= 1'b0;
    endtask

    initial begin
        k = $urandom(32'h41d16d04);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(OSC_MODE_OFF, 32'h0);
        rd_chk(TIMER_MODE_OFF, 32'h0);
        rd_chk(TIMER_RUN_OFF, 32'h0);
        rd_chk(STATUS_OFF, 32'h07);
        rd_chk(8'hF0, 32'h0);
        axi_wr(8'hF4, 32'hFF);
        for (int j = 0; j < 6; j++) begin
            axi_wr(TIMER_MODE_OFF, $urandom);
            axi_wr(TIMER_RUN_OFF, $urandom);
            rd_chk(TIMER_MODE_OFF, tmr_m);
            rd_chk(TIMER_RUN_OFF, run_m);
            check({t1_fast, t0_fast, t1_act, t0_act}, {tmr_m[3:2], run_m[1:0]});
        end
        count_ticks(512, n, k);
        check(n >= 127 && n <= 129, 1'b1);
        axi_wr(OSC_MODE_OFF, 32'h04);
        check(clk_low, 1'b1);
        count_ticks(512, n, k);
        check(n * 4 >= k - 4 && n * 4 <= k + 4, 1'b1);
        axi_wr(OSC_MODE_OFF, 32'h06);
        check(hosc_run, 1'b0);
        check(lrc_run, 1'b1);
        axi_wr(OSC_MODE_OFF, 32'h04);
        // Software lets the restarted high oscillator settle before leaving slow mode.
        repeat (64) @(posedge aclk);
        axi_wr(OSC_MODE_OFF, 32'h00);
        check(clk_low, 1'b0);
        axi_wr(OSC_MODE_OFF, 32'h18);
        check(cpu_run, 1'b1);
        rd_chk(OSC_MODE_OFF, osc_m);
        axi_wr(TIMER_MODE_OFF, 32'h0);
        axi_wr(TIMER_RUN_OFF, 32'h1);
        axi_wr(OSC_MODE_OFF, 32'h14);
        check({cpu_run, lrc_run, t0_act}, 3'h1);
        wdog <= 1'b1;
        repeat (4) @(posedge aclk);
        check(lrc_run, 1'b1);
        pulse_ovf();
        repeat (8) @(posedge aclk);
        check(cpu_run, 1'b0);
        wake_port <= wake_port ^ (8'h01 << $urandom_range(7, 0));
        wait_for(0, 1'b1, 20);
        check(clk_low, 1'b1);
        check(saw_settle, 1'b0);
        osc_m[4:3] = 2'h0;
        rd_chk(OSC_MODE_OFF, osc_m);
        axi_wr(TIMER_MODE_OFF, 32'h02);
        axi_wr(OSC_MODE_OFF, 32'h10);
        check({cpu_run, lrc_run}, 2'h1);
        pulse_ovf();
        wait_for(0, 1'b1, 6);
        check(clk_low, 1'b0);
        osc_m[4:3] = 2'h0;
        axi_wr(OSC_MODE_OFF, 32'h0C);
        check({cpu_run, hosc_run, lrc_run, t0_act}, 4'h0);
        pulse_ovf();
        repeat (8) @(posedge aclk);
        check({settling, cpu_run}, 2'h0);
        wake_port <= wake_port ^ (8'h01 << $urandom_range(7, 0));
        wait_for(1, 1'b1, 10);
        check(hosc_run, 1'b1);
        n = h_rises;
        wait_for(0, 1'b1, 100);
        n = h_rises - n;
        check(n >= ST && n <= ST + 2, 1'b1);
        check(clk_low, 1'b0);
        osc_m = 0;
        rd_chk(OSC_MODE_OFF, osc_m);
        rd_chk(STATUS_OFF, 32'h17);
        end_of_test();
    end
endmodule
